/* its_addr_sel.sv */
// Classifies what the address-select pin is tied to while the address byte arrives.
`timescale 1ns/1ps
module its_addr_sel
	import its_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic clear,
	input wire logic enable,
	input wire logic scl_rise,
	input wire logic scl_fall,
	input wire logic sda_lvl,
	input wire logic pin_lvl,
	output logic [2:0] sel
);
	logic seen_one;
	logic seen_zero;
	logic sda_diff;

	// The pin is sampled at both clock edges and compared with SDA only at rising edges, where SDA is stable.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			seen_one <= 1'b0;
			seen_zero <= 1'b0;
			sda_diff <= 1'b0;
		end else if (clear) begin
			seen_one <= 1'b0;
			seen_zero <= 1'b0;
			sda_diff <= 1'b0;
		end else if (enable && (scl_rise || scl_fall)) begin
			if (pin_lvl) begin
				seen_one <= 1'b1;
			end else begin
				seen_zero <= 1'b1;
			end
			if (scl_rise && (pin_lvl != sda_lvl)) begin
				sda_diff <= 1'b1;
			end
		end
	end

	always_comb begin
		if (!seen_one) begin
			sel = SEL_GND;
		end else if (!seen_zero) begin
			sel = SEL_VDD;
		end else if (!sda_diff) begin
			sel = SEL_SDA;
		end else begin
			sel = SEL_SCL;
		end
	end
endmodule

/* its_ctl.sv */
// Behavioural I2C bus controller that drives the target's clock and data lines.
`timescale 1ns/1ps
module its_ctl #(
	parameter int Q = 10
) (
	input wire logic mclk,
	input wire logic sda,
	output logic scl,
	output logic sda_drv
);
	// A high drive value releases the line to its pull-up; the clock stays high between frames.
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic q;
		repeat (Q) @(negedge mclk);
	endtask
	// Serves as start and as repeated start.
	task automatic start;
		sda_drv = 1'b1;
		q;
		scl = 1'b1;
		q;
		sda_drv = 1'b0;
		q;
		scl = 1'b0;
		q;
	endtask
	task automatic stop;
		sda_drv = 1'b0;
		q;
		scl = 1'b1;
		q;
		sda_drv = 1'b1;
		q;
	endtask
	task automatic bit_x(input logic b, output logic r);
		sda_drv = b;
		q;
		scl = 1'b1;
		q;
		r = sda;
		q;
		scl = 1'b0;
		q;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
		end
		bit_x(1'b1, r);
		ack = ~r;
	endtask
	task automatic rbyte(input logic ack_it, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, d[i]);
		end
		bit_x(~ack_it, r);
	endtask
endmodule

/* its_pkg.sv */
// Constants and types shared by the I2C target register access block.
package its_pkg;

	localparam logic [3:0] ADDR_FIXED = 4'h9;
	localparam logic [6:0] ADDR_BCAST = 7'h47;
	localparam logic [6:0] ADDR_GCALL = 7'h00;
	localparam logic [7:0] GCALL_RESET = 8'h06;

	localparam logic [2:0] SEL_GND = 3'h0;
	localparam logic [2:0] SEL_VDD = 3'h1;
	localparam logic [2:0] SEL_SDA = 3'h2;
	localparam logic [2:0] SEL_SCL = 3'h3;

	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] TX_LAST_BIT = 4'h7;
	localparam int WRITE_FRAME_CYCLES = 36;

	localparam logic LINE_IDLE = 1'b1;
	localparam logic RW_READ = 1'b1;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RX = 3'h1,
		ST_RX_ACK = 3'h2,
		ST_TX = 3'h3,
		ST_TX_ACK = 3'h4,
		ST_SKIP = 3'h5
	} its_state_t;

	typedef enum logic [2:0] {
		K_ADDR = 3'h0,
		K_CMD = 3'h1,
		K_HI = 3'h2,
		K_LO = 3'h3,
		K_GC = 3'h4
	} its_kind_t;

endpackage

/* its_sync.sv */
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module its_sync #(
	parameter int W = 3,
	parameter logic [W-1:0] RST_VAL = '1
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge mclk) begin
				if (!rst_b) begin
					s1[i] <= RST_VAL[i];
					s2[i] <= RST_VAL[i];
					s3[i] <= RST_VAL[i];
					dout[i] <= RST_VAL[i];
				end else begin
					s1[i] <= din[i];
					s2[i] <= s1[i];
					s3[i] <= s2[i];
					if (s2[i] == s3[i]) begin
						dout[i] <= s3[i];
					end
				end
			end
		end
	endgenerate
endmodule

/* its_target.sv */
// I2C target front end: address decode, register write and read-back sequencing.
// Function
// - Acknowledge each received byte by holding SDA low through the ninth clock high; a general-call byte other than 0x06 gets none.
// - Update needs both data bytes; upper byte 15:8 arrives before lower 7:0.
// - Apply the write on the clock fall ending the lower byte's acknowledge.
// - On stop release the bus, go idle, await a new start.
// - First byte is seven address bits plus direction; top four bits are 1001.
// - Sample the address-select pin during every first byte and latch it.
// - Pin to ground 000, supply 001, data line 010, clock line 011.
// - Also accept broadcast 1000111 with direction 0, regardless of the pin.
// - Broadcast address serves writes only, never reads.
// - The byte after the address selects the target register.
// - Repeated start, address with direction 1; device returns upper then lower byte.
// - General call 0x00 then 0x06 asserts software reset at that acknowledge's rise.
// - Seven-bit addressing only; acknowledge only own, broadcast or general call.
`timescale 1ns/1ps
module its_target
	import its_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic addr_select_pin,
	output logic [7:0] reg_addr,
	output logic reg_wr_en,
	output logic [15:0] reg_wr_data,
	input wire logic [15:0] reg_rd_data,
	output logic sw_reset
);
	logic scl;
	logic sda;
	logic pin;
	logic scl_d;
	logic sda_d;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;
	its_state_t state;
	its_kind_t kind;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] hi_byte;
	logic [7:0] lo_byte;
	logic [2:0] addr_low;
	logic [2:0] pin_sel;
	logic rd_mode;
	logic gc_mode;
	logic tx_lo;
	logic master_ack;
	logic next_ack;

	function automatic logic own_match(input logic [7:0] b, input logic [2:0] low3);
		own_match = (b[7:1] == {ADDR_FIXED, low3});
	endfunction

	function automatic logic bcast_write(input logic [7:0] b);
		bcast_write = (b[7:1] == ADDR_BCAST) && (b[0] != RW_READ);
	endfunction

	function automatic logic gcall_write(input logic [7:0] b);
		gcall_write = (b[7:1] == ADDR_GCALL) && (b[0] != RW_READ);
	endfunction

	its_sync #(
		.W(3),
		.RST_VAL(3'h7)
	) u_sync (
		.mclk(mclk),
		.rst_b(rst_b),
		.din({addr_select_pin, sda_in, scl_in}),
		.dout({pin, sda, scl})
	);

	its_addr_sel u_addr_sel (
		.mclk(mclk),
		.rst_b(rst_b),
		.clear(start),
		.enable((state == ST_RX) && (kind == K_ADDR)),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.sda_lvl(sda),
		.pin_lvl(pin),
		.sel(pin_sel)
	);

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			scl_d <= LINE_IDLE;
			sda_d <= LINE_IDLE;
		end else begin
			scl_d <= scl;
			sda_d <= sda;
		end
	end

	assign scl_rise = scl && !scl_d;
	assign scl_fall = !scl && scl_d;
	assign start = scl && scl_d && sda_d && !sda;
	assign stop = scl && scl_d && !sda_d && sda;

	// Acknowledge decision for the byte just shifted in.
	always_comb begin
		unique case (kind)
			K_ADDR: begin
				next_ack = own_match(shreg, pin_sel) || bcast_write(shreg) ||
					gcall_write(shreg);
			end
			K_GC: begin
				next_ack = (shreg == GCALL_RESET);
			end
			K_CMD, K_HI, K_LO: begin
				next_ack = 1'b1;
			end
			default: begin
				next_ack = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state <= ST_IDLE;
			kind <= K_ADDR;
			bit_cnt <= '0;
			shreg <= '0;
			hi_byte <= '0;
			lo_byte <= '0;
			addr_low <= SEL_GND;
			rd_mode <= 1'b0;
			gc_mode <= 1'b0;
			tx_lo <= 1'b0;
			master_ack <= 1'b0;
			reg_addr <= '0;
		end else if (start) begin
			// A new frame drops any half-received data pair.
			state <= ST_RX;
			kind <= K_ADDR;
			bit_cnt <= '0;
		end else if (stop) begin
			state <= ST_IDLE;
			kind <= K_ADDR;
		end else begin
			unique case (state)
				ST_IDLE, ST_SKIP: begin
				end
				ST_RX: begin
					if (scl_rise && (bit_cnt != BYTE_BITS)) begin
						shreg <= {shreg[6:0], sda};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && (bit_cnt == BYTE_BITS)) begin
						bit_cnt <= '0;
						state <= next_ack ? ST_RX_ACK : ST_SKIP;
						if (kind == K_ADDR) begin
							addr_low <= pin_sel;
							rd_mode <= shreg[0];
							gc_mode <= gcall_write(shreg);
						end
					end
				end
				ST_RX_ACK: begin
					if (scl_fall) begin
						state <= ST_RX;
						unique case (kind)
							K_ADDR: begin
								if (rd_mode) begin
									// Read-back data is taken once, at the end of the address ack.
									shreg <= reg_rd_data[15:8];
									lo_byte <= reg_rd_data[7:0];
									tx_lo <= 1'b0;
									state <= ST_TX;
								end else begin
									kind <= gc_mode ? K_GC : K_CMD;
								end
							end
							K_CMD: begin
								reg_addr <= shreg;
								kind <= K_HI;
							end
							K_HI: begin
								hi_byte <= shreg;
								kind <= K_LO;
							end
							K_LO: begin
								kind <= K_HI;
							end
							K_GC: begin
								state <= ST_SKIP;
							end
						endcase
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt == TX_LAST_BIT) begin
							bit_cnt <= '0;
							state <= ST_TX_ACK;
						end else begin
							shreg <= {shreg[6:0], 1'b0};
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
				end
				ST_TX_ACK: begin
					if (scl_rise) begin
						master_ack <= !sda;
					end else if (scl_fall) begin
						if (master_ack && !tx_lo) begin
							shreg <= lo_byte;
							tx_lo <= 1'b1;
							state <= ST_TX;
						end else begin
							state <= ST_SKIP;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Write strobe and data, issued on the fall that ends the lower byte's ack.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			reg_wr_en <= 1'b0;
			reg_wr_data <= '0;
		end else if (!start && !stop && (state == ST_RX_ACK) && (kind == K_LO) && scl_fall) begin
			reg_wr_en <= 1'b1;
			reg_wr_data <= {hi_byte, shreg};
		end else begin
			reg_wr_en <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			sw_reset <= 1'b0;
		end else begin
			sw_reset <= !start && !stop && (state == ST_RX_ACK) && (kind == K_GC) && scl_rise;
		end
	end

	// Open-drain data line: only ever pulled low.
	assign sda_out = 1'b0;
	assign sda_oe = (state == ST_RX_ACK) || ((state == ST_TX) && !shreg[7]);

	sequence s_ack_hold;
		(state == ST_RX_ACK) && scl_rise;
	endsequence

	sequence s_ack_due;
		(state == ST_RX) && scl_fall && (bit_cnt == BYTE_BITS) && next_ack && !start && !stop;
	endsequence

	// An accepted byte must turn into a pull-down that outlasts the sync delay.
	property p_ack_low;
		@(posedge mclk) disable iff (!rst_b)
		s_ack_due |=> sda_oe [*8];
	endproperty
	a_ack_low: assert property (p_ack_low) else $error("ack not driven low");

	property p_wr_timing;
		@(posedge mclk) disable iff (!rst_b)
		reg_wr_en |-> $past(scl_fall) && ($past(state) == ST_RX_ACK) && ($past(kind) == K_LO);
	endproperty
	a_wr_timing: assert property (p_wr_timing) else $error("write not at ack fall");

	property p_wr_pair;
		@(posedge mclk) disable iff (!rst_b)
		reg_wr_en |-> (reg_wr_data[15:8] == hi_byte) && (reg_wr_data[7:0] == shreg);
	endproperty
	a_wr_pair: assert property (p_wr_pair) else $error("data bytes out of order");

	property p_stop_idle;
		@(posedge mclk) disable iff (!rst_b)
		(stop && !start) |=> (state == ST_IDLE) && !sda_oe;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("bus not released on stop");

	property p_addr_ok;
		@(posedge mclk) disable iff (!rst_b)
		($rose(state == ST_RX_ACK) && (kind == K_ADDR)) |->
			(shreg[7:1] == {ADDR_FIXED, addr_low}) || bcast_write(shreg) || gcall_write(shreg);
	endproperty
	a_addr_ok: assert property (p_addr_ok) else $error("acked a foreign address");

	property p_no_bcast_read;
		@(posedge mclk) disable iff (!rst_b)
		((state == ST_RX_ACK) && (kind == K_ADDR) && (shreg[7:1] == ADDR_BCAST)) |-> !shreg[0];
	endproperty
	a_no_bcast_read: assert property (p_no_bcast_read) else $error("broadcast read acked");

	property p_gc_reset;
		@(posedge mclk) disable iff (!rst_b)
		(s_ack_hold ##0 (kind == K_GC)) |=> sw_reset ##1 !sw_reset;
	endproperty
	a_gc_reset: assert property (p_gc_reset) else $error("general call reset missing");

	property p_start_discard;
		@(posedge mclk) disable iff (!rst_b)
		start |=> ((kind == K_ADDR) && !reg_wr_en) [*8];
	endproperty
	a_start_discard: assert property (p_start_discard) else $error("write after restart");

	property p_read_load;
		@(posedge mclk) disable iff (!rst_b)
		((state == ST_RX_ACK) && (kind == K_ADDR) && rd_mode && scl_fall && !start && !stop)
			|=> (state == ST_TX) && (shreg == $past(reg_rd_data[15:8]));
	endproperty
	a_read_load: assert property (p_read_load) else $error("upper byte not loaded");

endmodule

/* its_target_bench.sv */
// Self-checking bench for the I2C target front end.
`timescale 1ns/1ps
module its_target_bench;
	import its_pkg::*;
	logic mclk, rst_b, scl, sda_drv, sda_out, sda_oe, pin, reg_wr_en, sw_reset, ack;
	logic [1:0] pin_mode;
	logic [7:0] reg_addr, hi, lo;
	logic [15:0] reg_wr_data, reg_rd_data, wr_last;
	int wr_cnt, gc_cnt, mismatches, comparisons, n0, n1, scl_rises;
	wire logic sda = sda_drv & (sda_oe ? sda_out : 1'b1);
	always_comb begin
		case (pin_mode)
			2'h0: pin = 1'b0;
			2'h1: pin = 1'b1;
			2'h2: pin = sda;
			default: pin = scl;
		endcase
	end
	its_target DUT (.mclk(mclk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .addr_select_pin(pin), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .sw_reset(sw_reset));
	its_ctl ctl (.mclk(mclk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
	always @(posedge mclk) begin
		if (reg_wr_en === 1'b1) begin
			wr_cnt++;
			wr_last = reg_wr_data;
		end
		if (sw_reset === 1'b1) begin
			gc_cnt++;
		end
	end
	always @(posedge scl) begin
		scl_rises++;
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string w);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t %s got %h want %h", $time, w, got, exp);
		end
	endtask
	task automatic wb(input logic [7:0] d, input logic exp, input string w);
		ctl.wbyte(d, ack);
		check(16'(ack), 16'(exp), w);
	endtask
	task automatic frame(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
		input logic ok);
		n0 = wr_cnt;
		ctl.start;
		n1 = scl_rises;
		wb({a, 1'b0}, ok, "address ack");
		if (ok) begin
			wb(c, 1'b1, "command ack");
			wb(d[15:8], 1'b1, "upper ack");
			check(16'(wr_cnt), 16'(n0), "early update");
			wb(d[7:0], 1'b1, "lower ack");
			check(16'(scl_rises - n1), 16'(WRITE_FRAME_CYCLES), "frame clocks");
			check(16'(wr_cnt), 16'(n0 + 1), "update count");
			check(wr_last, d, "update data");
			check({8'h0, reg_addr}, {8'h0, c}, "register select");
		end
		ctl.stop;
		check(16'(wr_cnt), 16'(n0 + int'(ok)), "frame count");
	endtask
	task automatic t_pin;
		for (int m = 0; m < 4; m++) begin
			pin_mode = 2'(m);
			frame({ADDR_FIXED, 3'(m)}, 8'h20 + 8'(m), 16'hb00d ^ 16'(m), 1'b1);
			frame({ADDR_FIXED, 3'(m + 1)}, 8'h20, 16'h0, 1'b0);
		end
		frame(7'h78, 8'h20, 16'h0, 1'b0);
		$display("test pin done");
	endtask
	task automatic t_bcast;
		pin_mode = 2'h1;
		frame(ADDR_BCAST, 8'h31, 16'h5a5a, 1'b1);
		ctl.start;
		wb({ADDR_BCAST, RW_READ}, 1'b0, "broadcast read");
		ctl.stop;
		$display("test broadcast done");
	endtask
	task automatic t_read;
		reg_rd_data = 16'hc3a5;
		n0 = wr_cnt;
		ctl.start;
		wb({ADDR_FIXED, SEL_VDD, 1'b0}, 1'b1, "read address");
		wb(8'h42, 1'b1, "read command");
		ctl.start;
		wb({ADDR_FIXED, SEL_VDD, RW_READ}, 1'b1, "read direction");
		ctl.rbyte(1'b1, hi);
		ctl.rbyte(1'b0, lo);
		ctl.stop;
		check({hi, lo}, 16'hc3a5, "read data");
		check(16'(wr_cnt), 16'(n0), "read wrote");
		$display("test read done");
	endtask
	task automatic t_part;
		n0 = wr_cnt;
		ctl.start;
		wb({ADDR_FIXED, SEL_VDD, 1'b0}, 1'b1, "partial address");
		wb(8'h55, 1'b1, "partial command");
		wb(8'h99, 1'b1, "partial upper");
		ctl.stop;
		check(16'(wr_cnt), 16'(n0), "partial write");
		check(16'(sda_oe), 16'h0, "bus release");
		frame({ADDR_FIXED, SEL_VDD}, 8'h55, 16'h1357, 1'b1);
		// A lone upper byte cut short by a repeated start must not pair with the next frame.
		ctl.start;
		wb({ADDR_FIXED, SEL_VDD, 1'b0}, 1'b1, "restart address");
		wb(8'h66, 1'b1, "restart command");
		wb(8'h77, 1'b1, "restart upper");
		frame({ADDR_FIXED, SEL_VDD}, 8'h67, 16'h2468, 1'b1);
		$display("test partial done");
	endtask
	task automatic t_gc;
		n0 = gc_cnt;
		ctl.start;
		wb({ADDR_GCALL, 1'b0}, 1'b1, "general call");
		wb(GCALL_RESET, 1'b1, "reset byte");
		check(16'(gc_cnt), 16'(n0 + 1), "software reset");
		ctl.stop;
		ctl.start;
		wb({ADDR_GCALL, 1'b0}, 1'b1, "general call");
		wb(8'h05, 1'b0, "other byte");
		ctl.stop;
		check(16'(gc_cnt), 16'(n0 + 1), "no reset");
		$display("test general call done");
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	initial begin
		rst_b = 1'b0;
		pin_mode = 2'h0;
		reg_rd_data = 16'h0;
		repeat (8) @(negedge mclk);
		rst_b = 1'b1;
		repeat (8) @(negedge mclk);
		t_pin;
		t_bcast;
		t_read;
		t_part;
		t_gc;
		results;
	end
	// The tests need about 19000 cycles; this cuts a hang short.
	initial begin
		repeat (90000) @(posedge mclk);
		mismatches++;
		results;
	end
endmodule
